// >>> hdl/txf_regs.sv
// txf_regs: apb register bank for transmit fifo lengths and control-cell interrupts.
// assumes the transmit engine and fifos run on clk and report lengths combinationally.
//
// Behaviour
// - transfer mask bit enables group completion interrupt
// - frame mask bit enables group frame interrupt
// - mask upper byte reads zero
// - masks reset to all cleared
// - eight link pair registers, reset 0x0101
// - link N low nibble, N+8 bits 11:8
// - four group pair registers, reset 0x0101
// - group N low nibble, N+4 bits 11:8
// - select codes pick link, group, free fifo
// - codes 0x20-0x2f pick modifier length
// - free length 6:0, others 4:0
// - transfer flag zero while busy, one done
// - frame flag zero when armed, one sent
`timescale 1ns/100ps
`default_nettype none
module txf_regs (
    input  wire logic                                        clk,
    input  wire logic                                        sys_rst,
    // apb slave
    input  wire logic                                        psel,
    input  wire logic                                        penable,
    input  wire logic                                        pwrite,
    input  wire logic [txf_pkg::ADDR_W-1:0]                  paddr,
    input  wire logic [txf_pkg::DATA_W-1:0]                  pwdata,
    input  wire logic [3:0]                                  pstrb,
    output var  logic [txf_pkg::DATA_W-1:0]                  prdata,
    output logic                                             pready,
    output logic                                             pslverr,
    // transmit engine events
    input  wire logic [txf_pkg::NGRP-1:0]                    xfer_done,
    input  wire logic [txf_pkg::NGRP-1:0]                    frame_sent,
    output logic      [txf_pkg::NGRP-1:0]                    xfer_start,
    output logic      [txf_pkg::NGRP-1:0]                    frame_arm,
    // fifo length settings
    output logic      [txf_pkg::NLINK-1:0][txf_pkg::LEN_W-1:0] link_depth,
    output logic      [txf_pkg::NGRP-1:0][txf_pkg::LEN_W-1:0]  group_depth,
    // current fifo fill levels
    input  wire logic [txf_pkg::NLINK-1:0][txf_pkg::FILL_W-1:0] link_fill,
    input  wire logic [txf_pkg::NGRP-1:0][txf_pkg::FILL_W-1:0]  group_fill,
    input  wire logic [txf_pkg::NLINK-1:0][txf_pkg::FILL_W-1:0] icp_mod_fill,
    input  wire logic [txf_pkg::FREE_W-1:0]                  free_fill,
    // interrupt
    output logic                                             irq
);
    // group count, used by the internal per-group vectors
    localparam int NG = txf_pkg::NGRP;

    logic [txf_pkg::IDX_W-1:0]  widx;
    logic                       setup;
    logic                       wr;
    logic [txf_pkg::REG_W-1:0]  rd_val;
    logic                       rd_hit;
    logic                       hit_link;
    logic                       hit_grp;
    logic [2:0]                 link_sel;
    logic [1:0]                 grp_sel;
    logic [txf_pkg::IDX_W-1:0]  link_off;
    logic [txf_pkg::IDX_W-1:0]  grp_off;
    // single-register hits and their write strobes
    logic                       hit_xflag;
    logic                       hit_fflag;
    logic                       hit_xmask;
    logic                       hit_fmask;
    logic                       hit_sel;
    logic                       hit_evt;
    logic                       wr_xflag;
    logic                       wr_fflag;
    logic                       wr_xmask;
    logic                       wr_fmask;
    logic                       wr_sel;
    logic                       wr_evt;

    logic [NG-1:0]              xfer_mask;
    logic [NG-1:0]              frame_mask;
    logic [txf_pkg::SEL_W-1:0]  fifo_sel;
    logic [txf_pkg::PAIR_W-1:0] link_pair [txf_pkg::NPAIRL];
    logic [txf_pkg::PAIR_W-1:0] grp_pair  [txf_pkg::NPAIRG];

    logic [NG-1:0]              xfer_flag;
    logic [NG-1:0]              frame_flag;
    logic [NG-1:0]              xfer_evt;
    logic [NG-1:0]              frame_evt;
    logic [2*NG-1:0]            evt_stat;
    logic [2*NG-1:0]            evt_clr;

    logic [txf_pkg::REG_W-1:0]  wval_link;
    logic [txf_pkg::REG_W-1:0]  wval_grp;
    logic [txf_pkg::REG_W-1:0]  wval_sel_xm;
    logic [txf_pkg::REG_W-1:0]  wval_sel_fm;
    logic [txf_pkg::REG_W-1:0]  wval_sel;
    logic [txf_pkg::FREE_W-1:0] fill_rd;
    logic [1:0]                 sel_cls;
    logic [3:0]                 sel_num;

    // merge the two low byte lanes into the current value of a 16-bit register
    // lanes 2 and 3 are ignored: every register here is sixteen bits
    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  st);
        logic [15:0] res;
        res[7:0]  = st[0] ? wd[7:0]  : old[7:0];
        res[15:8] = st[1] ? wd[15:8] : old[15:8];
        return res;
    endfunction : lane_merge

    // apb decode; zero wait states, so the slave is always ready
    // an unmapped place is refused at once with pslverr
    assign widx     = paddr[txf_pkg::ADDR_W-1:2];
    assign setup    = psel & ~penable;
    assign wr       = psel & penable & pwrite & rd_hit;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~rd_hit;
    assign hit_link = (widx >= txf_pkg::IDX_LINK_FIRST) && (widx <= txf_pkg::IDX_LINK_LAST);
    assign hit_grp  = (widx >= txf_pkg::IDX_GRP_FIRST) && (widx <= txf_pkg::IDX_GRP_LAST);
    assign link_off = widx - txf_pkg::IDX_LINK_FIRST;
    assign grp_off  = widx - txf_pkg::IDX_GRP_FIRST;
    assign link_sel = link_off[2:0];
    assign grp_sel  = grp_off[1:0];

    // one compare per register, shared by write strobes and read decode
    assign hit_xflag = (widx == txf_pkg::IDX_XFER_FLAG);
    assign hit_fflag = (widx == txf_pkg::IDX_FRAME_FLAG);
    assign hit_xmask = (widx == txf_pkg::IDX_XFER_MASK);
    assign hit_fmask = (widx == txf_pkg::IDX_FRAME_MASK);
    assign hit_sel   = (widx == txf_pkg::IDX_FIFO_SEL);
    assign hit_evt   = (widx == txf_pkg::IDX_EVT_STAT);

    // write strobes; wr already drops refused places
    assign wr_xflag  = wr & hit_xflag;
    assign wr_fflag  = wr & hit_fflag;
    assign wr_xmask  = wr & hit_xmask;
    assign wr_fmask  = wr & hit_fmask;
    assign wr_sel    = wr & hit_sel;
    assign wr_evt    = wr & hit_evt;

    // merged write values per register view
    // a lane left out keeps its stored byte
    assign wval_sel_xm = lane_merge({8'h00, xfer_mask}, pwdata, pstrb);
    assign wval_sel_fm = lane_merge({8'h00, frame_mask}, pwdata, pstrb);
    assign wval_link   = lane_merge({4'h0, link_pair[link_sel]}, pwdata, pstrb);
    assign wval_grp    = lane_merge({4'h0, grp_pair[grp_sel]}, pwdata, pstrb);
    assign wval_sel    = lane_merge({10'h000, fifo_sel}, pwdata, pstrb);

    txf_field_reg #(.W(NG), .RST_VAL(txf_pkg::RST_MASK)) u_xfer_mask (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wr_en   (wr_xmask),
        .wdata   (wval_sel_xm[NG-1:0]),
        .q       (xfer_mask)
    );

    txf_field_reg #(.W(NG), .RST_VAL(txf_pkg::RST_MASK)) u_frame_mask (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wr_en   (wr_fmask),
        .wdata   (wval_sel_fm[NG-1:0]),
        .q       (frame_mask)
    );

    // the select is write-only; a read returns the chosen length
    // select field write
    txf_field_reg #(.W(txf_pkg::SEL_W), .RST_VAL(txf_pkg::RST_SEL)) u_fifo_sel (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wr_en   (wr_sel),
        .wdata   (wval_sel[txf_pkg::SEL_W-1:0]),
        .q       (fifo_sel)
    );

    // pair registers; bits 7:4 are stored as written and steer nothing
    // link N+8 and group N+4 use bits 11:8 of the same word
    genvar gi;
    generate
        for (gi = 0; gi < txf_pkg::NPAIRL; gi++) begin : g_link
            txf_field_reg #(.W(txf_pkg::PAIR_W), .RST_VAL(txf_pkg::RST_PAIR)) u_pair (
                .clk     (clk),
                .sys_rst (sys_rst),
                .wr_en   (wr && hit_link && link_sel == gi),
                .wdata   (wval_link[txf_pkg::PAIR_W-1:0]),
                .q       (link_pair[gi])
            );
            assign link_depth[gi]     = link_pair[gi][txf_pkg::PAIR_LO_LSB +: txf_pkg::LEN_W];
            assign link_depth[gi + txf_pkg::NPAIRL] =
                link_pair[gi][txf_pkg::PAIR_HI_LSB +: txf_pkg::LEN_W];
        end
        for (gi = 0; gi < txf_pkg::NPAIRG; gi++) begin : g_grp
            txf_field_reg #(.W(txf_pkg::PAIR_W), .RST_VAL(txf_pkg::RST_PAIR)) u_pair (
                .clk     (clk),
                .sys_rst (sys_rst),
                .wr_en   (wr && hit_grp && grp_sel == gi),
                .wdata   (wval_grp[txf_pkg::PAIR_W-1:0]),
                .q       (grp_pair[gi])
            );
            assign group_depth[gi]     = grp_pair[gi][txf_pkg::PAIR_LO_LSB +: txf_pkg::LEN_W];
            assign group_depth[gi + txf_pkg::NPAIRG] =
                grp_pair[gi][txf_pkg::PAIR_HI_LSB +: txf_pkg::LEN_W];
        end
        for (gi = 0; gi < NG; gi++) begin : g_evt
            // a zero in lane 0 opens a request; a one does nothing
            // transfer flag cycle
            txf_evt_cell u_xfer (
                .clk     (clk),
                .sys_rst (sys_rst),
                .arm     (wr_xflag && pstrb[0] && !pwdata[gi]),
                .done    (xfer_done[gi]),
                .clr     (evt_clr[gi]),
                .flag    (xfer_flag[gi]),
                .sticky  (xfer_evt[gi]),
                .start   (xfer_start[gi])
            );
            // frame indication arms the same way on its own register
            // frame flag cycle
            txf_evt_cell u_frame (
                .clk     (clk),
                .sys_rst (sys_rst),
                .arm     (wr_fflag && pstrb[0] && !pwdata[gi]),
                .done    (frame_sent[gi]),
                .clr     (evt_clr[gi + txf_pkg::EVT_FRAME_LSB]),
                .flag    (frame_flag[gi]),
                .sticky  (frame_evt[gi]),
                .start   (frame_arm[gi])
            );
        end
    endgenerate

    // write-one-to-clear of the sticky events, per byte lane
    // an event landing in the clearing cycle survives, so none is lost
    assign evt_clr  = wr_evt ?
                      {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00} :
                      16'h0000;
    assign evt_stat = {frame_evt, xfer_evt};

    // level output: high until the event or its enable is cleared
    // masked interrupt level
    assign irq = |(xfer_evt & xfer_mask) | |(frame_evt & frame_mask);

    // fifo length readback mux; unlisted codes read zero
    // so a bad select shows as zero, never as a neighbour's length
    assign sel_cls = fifo_sel[5:4];
    assign sel_num = fifo_sel[3:0];
    assign fill_rd =
        (fifo_sel == txf_pkg::SEL_FREE)                  ? free_fill :
        (sel_cls == txf_pkg::SEL_CLS_LINK)               ? {2'b00, link_fill[sel_num]} :
        (sel_cls == txf_pkg::SEL_CLS_GRP && !sel_num[3]) ? {2'b00, group_fill[sel_num[2:0]]} :
        (sel_cls == txf_pkg::SEL_CLS_ICP)                ? {2'b00, icp_mod_fill[sel_num]} :
                                                           7'h00;

    // read decode; unused high bits always zero
    always_comb begin
        rd_val = 16'h0000;
        rd_hit = 1'b1;
        if (hit_xflag) begin
            rd_val = {8'h00, xfer_flag};
        end else if (hit_fflag) begin
            rd_val = {8'h00, frame_flag};
        end else if (hit_xmask) begin
            rd_val = {8'h00, xfer_mask};
        end else if (hit_fmask) begin
            rd_val = {8'h00, frame_mask};
        end else if (hit_link) begin
            rd_val = {4'h0, link_pair[link_sel]};
        end else if (hit_grp) begin
            rd_val = {4'h0, grp_pair[grp_sel]};
        end else if (hit_sel) begin
            rd_val = {9'h000, fill_rd};
        end else if (hit_evt) begin
            rd_val = evt_stat;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // read data captured in the setup cycle so it is a flop in the access cycle
    // trade-off: the value is the one seen a cycle before completion
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= {16'h0000, rd_val};
        end
    end

    // bits 7:4 of the pair registers belong to software, which writes zero;
    // nothing downstream reads them, so a stray value there is harmless
endmodule : txf_regs
`default_nettype wire

// >>> shared/txf_pkg.sv
// txf_pkg: constants for the transmit fifo length and control-cell interrupt registers.
// assumes a 32-bit apb slave with register word index = byte address / 4.
`default_nettype none
package txf_pkg;
    // widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;
    localparam int NGRP   = 8;
    localparam int NLINK  = 16;
    localparam int NPAIRL = 8;
    localparam int NPAIRG = 4;
    localparam int LEN_W  = 4;
    localparam int PAIR_W = 12;
    localparam int FILL_W = 5;
    localparam int FREE_W = 7;
    localparam int SEL_W  = 6;
    localparam int IDX_W  = 10;

    // register indices (byte address is four times the index)
    localparam logic [IDX_W-1:0] IDX_XFER_FLAG  = 10'h086;
    localparam logic [IDX_W-1:0] IDX_FRAME_FLAG = 10'h087;
    localparam logic [IDX_W-1:0] IDX_XFER_MASK  = 10'h088;
    localparam logic [IDX_W-1:0] IDX_FRAME_MASK = 10'h089;
    localparam logic [IDX_W-1:0] IDX_LINK_FIRST = 10'h08b;
    localparam logic [IDX_W-1:0] IDX_LINK_LAST  = 10'h092;
    localparam logic [IDX_W-1:0] IDX_GRP_FIRST  = 10'h093;
    localparam logic [IDX_W-1:0] IDX_GRP_LAST   = 10'h096;
    localparam logic [IDX_W-1:0] IDX_FIFO_SEL   = 10'h09b;
    localparam logic [IDX_W-1:0] IDX_EVT_STAT   = 10'h0a0;

    // reset values
    localparam logic [NGRP-1:0]   RST_MASK = 8'h00;
    localparam logic [PAIR_W-1:0] RST_PAIR = 12'h101;
    localparam logic [SEL_W-1:0]  RST_SEL  = 6'h00;
    localparam logic              RST_FLAG = 1'b1;

    // pair register field positions
    localparam int PAIR_LO_LSB = 0;
    localparam int PAIR_HI_LSB = 8;

    // event status layout: transfer done in low byte, frame indication in high byte
    localparam int EVT_FRAME_LSB = 8;

    // fifo select code classes, taken from select bits 5:4
    localparam logic [1:0]       SEL_CLS_LINK = 2'h0;
    localparam logic [1:0]       SEL_CLS_GRP  = 2'h1;
    localparam logic [1:0]       SEL_CLS_ICP  = 2'h2;
    localparam logic [SEL_W-1:0] SEL_FREE     = 6'h18;
endpackage : txf_pkg
`default_nettype wire

// >>> hdl/txf_field_reg.sv
// txf_field_reg: one software-written field with a constant reset value.
// assumes the write strobe comes from the apb decode on the same clock.
`timescale 1ns/100ps
`default_nettype none
module txf_field_reg #(
    parameter int             W       = 8,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wdata,
    output var  logic [W-1:0] q
);
    // plain storage; reserved bits are kept as written
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= RST_VAL;
        end else if (wr_en) begin
            q <= wdata;
        end
    end
endmodule : txf_field_reg
`default_nettype wire

// >>> hdl/txf_evt_cell.sv
// txf_evt_cell: one group's start/arm flag with its sticky completion event.
// assumes done is a one-cycle pulse from the transmit engine on clk.
`timescale 1ns/100ps
`default_nettype none
module txf_evt_cell (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic arm,
    input  wire logic done,
    input  wire logic clr,
    output var  logic flag,
    output var  logic sticky,
    output var  logic start
);
    logic flag_nxt;
    logic rise;

    // a new arm wins over a done in the same cycle: the new request is still open
    assign flag_nxt = arm ? 1'b0 : (done ? 1'b1 : flag);
    // only a completion of an open request counts as an event
    assign rise     = done & ~flag & ~arm;

    // flag reads zero while open, one once complete
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag <= txf_pkg::RST_FLAG;
        end else begin
            flag <= flag_nxt;
        end
    end

    // sticky event; a set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sticky <= 1'b0;
        end else begin
            sticky <= rise | (sticky & ~clr);
        end
    end

    // one-cycle start pulse toward the transmit engine
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            start <= 1'b0;
        end else begin
            start <= arm;
        end
    end
endmodule : txf_evt_cell
`default_nettype wire

// >>> verification/txf_regs_chk.sv
// txf_regs_chk: concurrent checks on the transmit fifo register bank ports.
// assumes zero-wait apb on one clk domain with synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module txf_regs_chk (
    input wire logic                                          clk,
    input wire logic                                          sys_rst,
    input wire logic                                          psel,
    input wire logic                                          penable,
    input wire logic                                          pwrite,
    input wire logic [txf_pkg::ADDR_W-1:0]                    paddr,
    input wire logic [txf_pkg::DATA_W-1:0]                    pwdata,
    input wire logic [txf_pkg::DATA_W-1:0]                    prdata,
    input wire logic [txf_pkg::NGRP-1:0]                      xfer_done,
    input wire logic [txf_pkg::NGRP-1:0]                      frame_sent,
    input wire logic [txf_pkg::NGRP-1:0]                      xfer_start,
    input wire logic [txf_pkg::NGRP-1:0]                      frame_arm,
    input wire logic [txf_pkg::NLINK-1:0][txf_pkg::LEN_W-1:0] link_depth,
    input wire logic [txf_pkg::NGRP-1:0][txf_pkg::LEN_W-1:0]  group_depth,
    input wire logic                                          irq
);
    // access decode; pair indices wrap so the first register maps to zero
    wire logic [txf_pkg::IDX_W-1:0] idx;
    wire logic                      rd_acc;
    wire logic                      wr_acc;
    wire logic                      is_mask;
    wire logic [2:0]                lnk;
    wire logic [1:0]                gi;
    wire logic                      irq_src;
    wire logic                      wr_xflag;
    wire logic                      wr_fflag;
    wire logic [3:0]                wd_lo;
    wire logic [3:0]                wd_hi;
    logic                           mask_set_r;
    assign idx     = paddr[11:2];
    assign rd_acc  = psel & penable & ~pwrite;
    assign wr_acc  = psel & penable & pwrite;
    assign is_mask = (idx == txf_pkg::IDX_XFER_MASK) || (idx == txf_pkg::IDX_FRAME_MASK);
    assign lnk     = idx[2:0] - 3'h3;
    assign gi      = idx[1:0] - 2'h3;
    // sampled helpers, so that each $past looks at one plain signal
    assign irq_src  = (|xfer_done) | (|frame_sent) | (wr_acc & is_mask);
    assign wr_xflag = wr_acc & (idx == txf_pkg::IDX_XFER_FLAG);
    assign wr_fflag = wr_acc & (idx == txf_pkg::IDX_FRAME_FLAG);
    assign wd_lo    = pwdata[3:0];
    assign wd_hi    = pwdata[11:8];

    // remembers any mask write since reset, irq must stay low before it
    always_ff @(posedge clk) begin
        if (sys_rst) mask_set_r <= 1'b0;
        else if (wr_acc && is_mask) mask_set_r <= 1'b1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_mask_upper_zero: assert property (
        rd_acc && is_mask |-> prdata[31:8] == 24'h0) else $error("mask upper bits set");
    chk_pair_upper_zero: assert property (
        rd_acc && idx >= txf_pkg::IDX_LINK_FIRST && idx <= txf_pkg::IDX_GRP_LAST
        |-> prdata[31:12] == 20'h0) else $error("pair upper bits set");
    chk_sel_upper_zero: assert property (
        rd_acc && idx == txf_pkg::IDX_FIFO_SEL |-> prdata[31:7] == 25'h0)
        else $error("select readback upper bits set");
    chk_irq_quiet: assert property (
        !mask_set_r |-> !irq) else $error("irq before any mask set");
    chk_irq_cause: assert property (
        $rose(irq) |-> $past(irq_src))
        else $error("irq rose without event or mask write");
    chk_start_cause: assert property (
        |xfer_start |-> $past(wr_xflag))
        else $error("start pulse without flag write");
    chk_arm_cause: assert property (
        |frame_arm |-> $past(wr_fflag))
        else $error("arm pulse without flag write");
    chk_link_depth: assert property (
        wr_acc && idx >= txf_pkg::IDX_LINK_FIRST && idx <= txf_pkg::IDX_LINK_LAST
        |=> link_depth[{1'b0, $past(lnk)}] == $past(wd_lo)
            && link_depth[{1'b1, $past(lnk)}] == $past(wd_hi))
        else $error("link depth not updated");
    chk_group_depth: assert property (
        wr_acc && idx >= txf_pkg::IDX_GRP_FIRST && idx <= txf_pkg::IDX_GRP_LAST
        |=> group_depth[{1'b0, $past(gi)}] == $past(wd_lo)
            && group_depth[{1'b1, $past(gi)}] == $past(wd_hi))
        else $error("group depth not updated");

    cov_start: cover property (|xfer_start);
    cov_irq: cover property ($rose(irq));
    cov_sel_read: cover property (rd_acc && idx == txf_pkg::IDX_FIFO_SEL);
endmodule : txf_regs_chk

bind txf_regs txf_regs_chk u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .xfer_done(xfer_done), .frame_sent(frame_sent), .xfer_start(xfer_start),
    .frame_arm(frame_arm), .link_depth(link_depth), .group_depth(group_depth), .irq(irq));
`default_nettype wire

// >>> verification/txf_eng_model.sv
// txf_eng_model: transmit engine and fifo fill levels behind the register bank.
// assumes start and arm are one-cycle pulses on clk.
`timescale 1ns/100ps
`default_nettype none
module txf_eng_model (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [7:0]       xfer_start,
    input  wire logic [7:0]       frame_arm,
    output var  logic [7:0]       xfer_done,
    output var  logic [7:0]       frame_sent,
    output var  logic [15:0][4:0] link_fill,
    output var  logic [15:0][4:0] icp_mod_fill,
    output var  logic [7:0][4:0]  group_fill,
    output var  logic [6:0]       free_fill
);
    int xc[8];
    int fc[8];
    // completion pulses
    // higher groups answer later, so quick and slow replies both occur
    always @(posedge clk) begin
        for (int g = 0; g < 8; g++) begin
            xfer_done[g]  <= !sys_rst && xc[g] == 1;
            frame_sent[g] <= !sys_rst && fc[g] == 1;
            xc[g] <= sys_rst ? 0 : xfer_start[g] ? 4 + 3 * g : (xc[g] > 0 ? xc[g] - 1 : 0);
            fc[g] <= sys_rst ? 0 : frame_arm[g] ? 4 + 3 * g : (fc[g] > 0 ? fc[g] - 1 : 0);
        end
    end
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            link_fill[i]    = 5'(i + 1);
            icp_mod_fill[i] = 5'(31 - i);
        end
        for (int g = 0; g < 8; g++) group_fill[g] = 5'(17 + g);
        free_fill = 7'h55;
    end
endmodule : txf_eng_model
`default_nettype wire

// >>> verification/tb_txf_regs.sv
// tb_txf_regs: apb sequences against the register bank with expected values.
// assumes the engine model fill pattern: link i+1, group 17+g, modifier 31-i, free 0x55.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_txf_regs;
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, er;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0]  pstrb = 4'hf;
    logic [7:0]  xfer_done, frame_sent, xfer_start, frame_arm;
    logic [15:0][3:0] link_depth;
    logic [7:0][3:0]  group_depth;
    logic [15:0][4:0] link_fill, icp_mod_fill;
    logic [7:0][4:0]  group_fill;
    logic [6:0]       free_fill;
    int mismatches = 0, num_checks = 0;

    txf_regs DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .xfer_done(xfer_done), .frame_sent(frame_sent),
        .xfer_start(xfer_start), .frame_arm(frame_arm), .link_depth(link_depth),
        .group_depth(group_depth), .link_fill(link_fill), .group_fill(group_fill),
        .icp_mod_fill(icp_mod_fill), .free_fill(free_fill), .irq(irq));
    txf_eng_model u_eng (.clk(clk), .sys_rst(sys_rst), .xfer_start(xfer_start),
        .frame_arm(frame_arm), .xfer_done(xfer_done), .frame_sent(frame_sent),
        .link_fill(link_fill), .icp_mod_fill(icp_mod_fill), .group_fill(group_fill),
        .free_fill(free_fill));

    // 200 mhz clock
    always #2.5 clk = ~clk;

    task print_verdict;
        if (mismatches == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    // one apb transfer; data and error are taken at the edge where pready is seen
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin @(posedge clk); n++; end while (!pready && n < 20);
        if (!pready) begin mismatches++; $display("MISMATCH t=%0t no ready", $time); print_verdict; end
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
    endtask : xfer

    task wr(input logic [11:0] a, input logic [31:0] d); xfer(1, a, d); endtask : wr
    task rdc(input logic [11:0] a, input logic [31:0] e); xfer(0, a, 0); `CHK(rd, e) endtask : rdc
    // irq is looked at once the edge updates have landed
    task irq_is(input logic e); #1; `CHK(irq, e) endtask : irq_is
    task poll(input logic [11:0] a, input int b);
        int n;
        n = 0;
        do begin xfer(0, a, 0); n++; end while (!rd[b] && n < 100);
        `CHK(rd[b], 1'b1)
    endtask : poll

    function automatic logic [31:0] exp_sel(input int c);
        if (c < 16) return 32'(c + 1);
        if (c < 24) return 32'(c + 1);
        if (c == 24) return 32'h55;
        if (c >= 32 && c < 48) return 32'(63 - c);
        return 32'h0;
    endfunction : exp_sel

    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 0;
        rdc(12'h220, 32'h0);
        rdc(12'h224, 32'h0);
        for (int i = 0; i < 8; i++) rdc(12'(12'h22c + 4 * i), 32'h101);
        for (int i = 0; i < 4; i++) rdc(12'(12'h24c + 4 * i), 32'h101);
        irq_is(0);
        wr(12'h220, 32'hffff_ffff); rdc(12'h220, 32'hff);
        wr(12'h224, 32'hffff_a5c3); rdc(12'h224, 32'hc3);
        wr(12'h224, 32'h0);
        // lane 1 alone must leave the enables in the low byte
        pstrb <= 4'h2; wr(12'h220, 32'h0); pstrb <= 4'hf; rdc(12'h220, 32'hff);
        // reserved bits 7:4 always written as zero
        for (int i = 0; i < 8; i++) begin
            wr(12'(12'h22c + 4 * i), 32'hffff_f000 | 32'(((i + 8) << 8) | (15 - i)));
            rdc(12'(12'h22c + 4 * i), 32'(((i + 8) << 8) | (15 - i)));
            `CHK(link_depth[i], 4'(15 - i))
            `CHK(link_depth[i + 8], 4'(i + 8))
        end
        for (int i = 0; i < 4; i++) begin
            wr(12'(12'h24c + 4 * i), 32'h0000_f000 | 32'(((i + 9) << 8) | (i + 2)));
            rdc(12'(12'h24c + 4 * i), 32'(((i + 9) << 8) | (i + 2)));
            `CHK(group_depth[i], 4'(i + 2))
            `CHK(group_depth[i + 4], 4'(i + 9))
        end
        for (int c = 0; c < 64; c++) begin
            wr(12'h26c, 32'hffff_ffc0 | 32'(c));
            rdc(12'h26c, exp_sel(c));
        end
        // unmapped place refuses and reads zero
        xfer(1, 12'h300, 32'h1234); `CHK(er, 1'b1)
        xfer(0, 12'h300, 32'h0); `CHK(rd, 32'h0)
        wr(12'h220, 32'h1);
        wr(12'h218, 32'hfe); rdc(12'h218, 32'hfe);
        poll(12'h218, 0); irq_is(1);
        rdc(12'h280, 32'h1);
        wr(12'h280, 32'h1); irq_is(0);
        wr(12'h218, 32'hf7); poll(12'h218, 3); irq_is(0);
        rdc(12'h280, 32'h8);
        wr(12'h280, 32'h8);
        wr(12'h224, 32'h20);
        wr(12'h21c, 32'hdf); rdc(12'h21c, 32'hdf);
        poll(12'h21c, 5); irq_is(1);
        rdc(12'h280, 32'h2000);
        wr(12'h224, 32'h0); irq_is(0);
        print_verdict;
    end
endmodule : tb_txf_regs
`default_nettype wire
